/* File: core/tsf_top.sv */
// Top: per-endpoint transmit set-presence flags behind a Wishbone slave
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
module tsf_top
    import tsf_pkg::*;
#(
    parameter int NUM_EP = 16,
    parameter int EP_W   = $clog2(NUM_EP)
) (
    input  wire logic            CLK_SYS,    // 200 MHz system clock
    input  wire logic            RESETN,     // Async reset, active low
    input  wire logic            WB_CYC_I,   // Bus cycle
    input  wire logic            WB_STB_I,   // Strobe
    input  wire logic            WB_WE_I,    // Write enable
    input  wire logic [3:0]      WB_SEL_I,   // Byte lanes
    input  wire logic [7:0]      WB_ADR_I,   // Byte address
    input  wire logic [31:0]     WB_DAT_I,   // Write data
    output logic      [31:0]     WB_DAT_O,   // Read data
    output logic                 WB_ACK_O,   // Acknowledge
    input  wire logic            TX_ACK_I,   // Set sent and acknowledged
    input  wire logic            TX_URUN_I,  // Transmit underrun seen
    input  wire logic [EP_W-1:0] TX_EP_I     // Endpoint of the two events
);
    typedef struct packed {
        logic                         ack;
        logic [31:0]                  rdata;
        logic [EP_W-1:0]              epsel;
        logic [NUM_EP-1:0][1:0]       pres;
        logic [NUM_EP-1:0]            oldest;
        logic [NUM_EP-1:0]            urun;
        logic [NUM_EP-1:0]            ovfl;
        logic [NUM_EP-1:0]            auto_tx_management;
        logic [NUM_EP-1:0][7:0]       count;
    } tsf_state_s;

    tsf_state_s st_r;
    tsf_state_s st_nxt;
    logic       rst_meta_r;
    logic       rst_sync_n_r;

    // Reset release through two stages, assertion stays asynchronous
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_r   <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r   <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // Bus decode helpers
    logic            req;
    logic            wr_lo;
    logic [EP_W-1:0] ep;
    assign req   = WB_CYC_I && WB_STB_I && !st_r.ack;
    // Only byte lane 0 carries register data
    assign wr_lo = req && WB_WE_I && WB_SEL_I[0];
    assign ep    = st_r.epsel;

    // Flag byte assembly for the selected endpoint
    function automatic logic [7:0] flag_byte(input tsf_state_s s,
                                             input logic [EP_W-1:0] e);
        logic [7:0] b;
        b = TSF_BYTE_ZERO;
        b[TSF_PRES_HI:TSF_PRES_LO] = s.pres[e];
        b[TSF_EMPTY] = (s.pres[e] == TSF_PRES_NONE);
        b[TSF_FULL]  = (s.pres[e] == TSF_PRES_BOTH);
        b[TSF_URUN]  = s.urun[e];
        b[TSF_OVFL]  = s.ovfl[e];
        return b;
    endfunction : flag_byte

    // Next state: bus access, then per-endpoint flag update
    always_comb begin
        logic fw_queue;
        logic fw_adv;
        logic fw_flush;
        logic hw_adv;
        logic advance;
        logic ovfl_set;
        logic urun_set;
        logic fw_flag_wr;
        logic [7:0] rd_byte;
        fw_queue   = 1'b0;
        fw_adv     = 1'b0;
        fw_flush   = 1'b0;
        hw_adv     = 1'b0;
        advance    = 1'b0;
        ovfl_set   = 1'b0;
        urun_set   = 1'b0;
        fw_flag_wr = 1'b0;
        rd_byte    = TSF_BYTE_ZERO;
        st_nxt     = st_r;
        // One-cycle ack, dropped in the cycle after it was given
        st_nxt.ack = req;

        // Read mux; unmapped addresses read as zero
        unique case (WB_ADR_I)
            TSF_ADDR_EPSEL: rd_byte = 8'(st_r.epsel);
            TSF_ADDR_FLAGS: rd_byte = flag_byte(st_r, ep);
            TSF_ADDR_COUNT: rd_byte = st_r.count[ep];
            TSF_ADDR_CTRL: begin
                // Flush and advance self-clear, so they read zero
                rd_byte = TSF_BYTE_ZERO;
                rd_byte[TSF_CTL_ATM] = st_r.auto_tx_management[ep];
            end
            default: rd_byte = TSF_BYTE_ZERO;
        endcase
        if (req && !WB_WE_I) begin
            st_nxt.rdata = {24'h000000, rd_byte};
        end

        // Write decode
        if (wr_lo) begin
            unique case (WB_ADR_I)
                TSF_ADDR_EPSEL: st_nxt.epsel = WB_DAT_I[EP_W-1:0];
                TSF_ADDR_FLAGS: fw_flag_wr = 1'b1;
                TSF_ADDR_COUNT: begin
                    st_nxt.count[ep] = WB_DAT_I[7:0];
                    fw_queue = 1'b1;
                end
                TSF_ADDR_CTRL: begin
                    st_nxt.auto_tx_management[ep] = WB_DAT_I[TSF_CTL_ATM];
                    fw_flush = WB_DAT_I[TSF_CTL_FLUSH];
                    // Firmware advance only counts outside auto mode
                    fw_adv = WB_DAT_I[TSF_CTL_ADV] && !WB_DAT_I[TSF_CTL_ATM]
                             && !WB_DAT_I[TSF_CTL_FLUSH];
                end
                default: ;
            endcase
        end

        // Per-endpoint update loop
        for (int i = 0; i < NUM_EP; i++) begin
            hw_adv   = TX_ACK_I && (TX_EP_I == EP_W'(i)) && st_r.auto_tx_management[i];
            urun_set = TX_URUN_I && (TX_EP_I == EP_W'(i));
            advance  = hw_adv || (fw_adv && (ep == EP_W'(i)));
            ovfl_set = 1'b0;
            // Underrun and overflow are writable; writing 0 clears
            if (fw_flag_wr && (ep == EP_W'(i))) begin
                st_nxt.urun[i] = WB_DAT_I[TSF_URUN];
                st_nxt.ovfl[i] = WB_DAT_I[TSF_OVFL];
            end
            if (fw_flush && (ep == EP_W'(i))) begin
                st_nxt.pres[i]   = TSF_PRES_NONE;
                st_nxt.oldest[i] = 1'b0;
                st_nxt.urun[i]   = 1'b0;
                st_nxt.ovfl[i]   = 1'b0;
            end else begin
                if (advance && (st_nxt.pres[i] != TSF_PRES_NONE)) begin
                    if (st_nxt.pres[i] == TSF_PRES_BOTH) begin
                        st_nxt.pres[i][st_nxt.oldest[i]] = 1'b0;
                        st_nxt.oldest[i] = !st_nxt.oldest[i];
                    end else begin
                        st_nxt.pres[i] = TSF_PRES_NONE;
                    end
                end
                if (fw_queue && (ep == EP_W'(i))) begin
                    unique case (st_nxt.pres[i])
                        TSF_PRES_NONE: begin
                            st_nxt.pres[i]   = TSF_PRES_SET0;
                            st_nxt.oldest[i] = 1'b0;
                        end
                        TSF_PRES_BOTH: ovfl_set = 1'b1;
                        default: begin
                            // Remaining set stays oldest
                            st_nxt.oldest[i] = st_nxt.pres[i][1];
                            st_nxt.pres[i]   = TSF_PRES_BOTH;
                        end
                    endcase
                end
                // Set wins over a simultaneous flag-register clear, not over a flush
                if (ovfl_set) begin
                    st_nxt.ovfl[i] = 1'b1;
                end
                if (urun_set) begin
                    st_nxt.urun[i] = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge CLK_SYS or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            st_r.ack    <= 1'b0;
            st_r.rdata  <= 32'h00000000;
            st_r.epsel  <= '0;
            st_r.pres   <= '0;
            st_r.oldest <= '0;
            st_r.urun   <= '0;
            st_r.ovfl   <= '0;
            st_r.auto_tx_management    <= {NUM_EP{TSF_ATM_RST}};
            st_r.count  <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign WB_ACK_O = st_r.ack;
    assign WB_DAT_O = st_r.rdata;
endmodule : tsf_top

/* File: core/tsf_pkg.sv */
// Package: register map, field layout and reset values of the set-flag block
package tsf_pkg;
    // Register byte addresses
    localparam logic [7:0] TSF_ADDR_EPSEL = 8'h00;
    localparam logic [7:0] TSF_ADDR_FLAGS = 8'h04;
    localparam logic [7:0] TSF_ADDR_COUNT = 8'h08;
    localparam logic [7:0] TSF_ADDR_CTRL  = 8'h0c;
    // Flag register field positions
    localparam int TSF_PRES_HI  = 7;
    localparam int TSF_PRES_LO  = 6;
    localparam int TSF_EMPTY    = 3;
    localparam int TSF_FULL     = 2;
    localparam int TSF_URUN     = 1;
    localparam int TSF_OVFL     = 0;
    // Control register field positions
    localparam int TSF_CTL_FLUSH = 7;
    localparam int TSF_CTL_ATM   = 2;
    localparam int TSF_CTL_ADV   = 1;
    // Reset values and encodings
    localparam logic [7:0] TSF_FLAGS_RST = 8'h08;
    localparam logic [1:0] TSF_PRES_NONE = 2'h0;
    localparam logic [1:0] TSF_PRES_SET0 = 2'h1;
    localparam logic [1:0] TSF_PRES_BOTH = 2'h3;
    localparam logic       TSF_ATM_RST   = 1'b1;
    localparam logic [7:0] TSF_BYTE_ZERO = 8'h00;
endpackage : tsf_pkg

/* File: test/tsf_asserts.sv */
// Checker: bus timing and flag layout seen at the tsf_top ports
`timescale 1ns/10ps
module tsf_asserts
    import tsf_pkg::*;
#(
    parameter int NUM_EP = 16,
    parameter int EP_W   = 4
) (
    input wire logic            CLK_SYS,   // Clock of all properties
    input wire logic            RESETN,    // Raw reset, active low
    input wire logic            WB_CYC_I,  // Bus cycle
    input wire logic            WB_STB_I,  // Strobe
    input wire logic            WB_WE_I,   // Write enable
    input wire logic [3:0]      WB_SEL_I,  // Byte lanes
    input wire logic [7:0]      WB_ADR_I,  // Byte address
    input wire logic [31:0]     WB_DAT_I,  // Write data
    input wire logic [31:0]     WB_DAT_O,  // Read data
    input wire logic            WB_ACK_O,  // Acknowledge
    input wire logic            TX_ACK_I,  // Set sent event
    input wire logic            TX_URUN_I, // Underrun event
    input wire logic [EP_W-1:0] TX_EP_I    // Endpoint of events
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);
    // New request and flag read being taken
    logic req, rdf;
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign rdf = req && !WB_WE_I && WB_ADR_I == TSF_ADDR_FLAGS;
    ack_lat_a: assert property (req |=> WB_ACK_O)
        else $error("no ack");
    ack_one_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack long");
    ack_cause_a: assert property (!WB_CYC_I |=> !WB_ACK_O)
        else $error("stray ack");
    dat_hold_a: assert property (
        !(WB_ACK_O && !WB_WE_I) |-> $stable(WB_DAT_O))
        else $error("read data moved");
    upper_zero_a: assert property (
        WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0) else $error("upper bits set");
    rsvd_zero_a: assert property (
        rdf |=> WB_DAT_O[5:4] == 2'h0) else $error("reserved bits set");
    empty_flag_a: assert property (
        rdf |=> WB_DAT_O[TSF_EMPTY] == (WB_DAT_O[7:6] == TSF_PRES_NONE))
        else $error("empty wrong");
    full_flag_a: assert property (
        rdf |=> WB_DAT_O[TSF_FULL] == (WB_DAT_O[7:6] == TSF_PRES_BOTH))
        else $error("full wrong");
    // Main scenarios reached
    cover property (rdf ##1 WB_DAT_O[7:6] == TSF_PRES_BOTH);
    cover property (rdf ##1 WB_DAT_O[TSF_OVFL]);
    cover property (TX_ACK_I);
endmodule : tsf_asserts
bind tsf_top tsf_asserts #(.NUM_EP(NUM_EP), .EP_W(EP_W)) u_chk (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .TX_ACK_I(TX_ACK_I), .TX_URUN_I(TX_URUN_I),
    .TX_EP_I(TX_EP_I));

/* File: test/tb_top.sv */
// Bench: random register and event traffic against a flag model
`timescale 1ns/10ps
module tb_top
    import tsf_pkg::*;
;
    logic        clk_sys = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ack;
    logic        tx_ack = 0, tx_urun = 0, nw [16], ur [16], ov [16], at [16];
    logic [3:0]  sel = 0, tx_ep = 0, sl;
    logic [7:0]  adr = 0, ra, cnt [16];
    logic [31:0] dat = 0, dat_o, rd, r, seed = 32'hecfccb34;
    logic [1:0]  pres [16];
    int          miscompares = 0, checks = 0, cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    tsf_top u_dut (.CLK_SYS(clk_sys), .RESETN(resetn), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr),
        .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .TX_ACK_I(tx_ack), .TX_URUN_I(tx_urun), .TX_EP_I(tx_ep));
    // Hang guard, run needs well under this
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Expected flag byte of one endpoint
    function automatic logic [31:0] fl(input int e);
        return {24'h0, pres[e], 2'h0, pres[e] == 2'h0, pres[e] == 2'h3,
                ur[e], ov[e]};
    endfunction : fl
    task automatic chk(input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk
    // Classic cycle; byte lanes random so lane 0 off is exercised
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_sys);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, r[31:28]};
        do @(posedge clk_sys); while (ack !== 1'b1);
        rd = dat_o;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic ev(input logic a);
        @(posedge clk_sys);
        {tx_ack, tx_urun, tx_ep} <= {a, !a, r[11:8]};
        @(posedge clk_sys);
        {tx_ack, tx_urun} <= 2'b00;
    endtask : ev
    task automatic adv(input int e);
        pres[e] = pres[e] == 2'h3 ? (nw[e] ? 2'h2 : 2'h1) : 2'h0;
    endtask : adv
    task automatic que(input int e);
        if (pres[e] == 2'h0) {pres[e], nw[e]} = 3'b010;
        else if (pres[e] == 2'h3) ov[e] = 1'b1;
        else {pres[e], nw[e]} = {2'h3, pres[e] == 2'h1};
    endtask : que
    task automatic test_done();
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    // Expected read value of any address; count survives a flush
    function automatic logic [31:0] rb(input logic [7:0] a);
        case (a)
            TSF_ADDR_EPSEL: return {28'h0, sl};
            TSF_ADDR_FLAGS: return fl(sl);
            TSF_ADDR_COUNT: return {24'h0, cnt[sl]};
            TSF_ADDR_CTRL:  return 32'(at[sl]) << TSF_CTL_ATM;
            default:        return 32'h0;
        endcase
    endfunction : rb
    // Reset, then reset values of every copy; bus idle on entry
    task automatic rst_chk();
        r = 32'hffffffff;
        resetn <= 1'b0;
        for (int e = 0; e < 16; e++) begin
            {pres[e], nw[e], ur[e], ov[e], at[e]} = 6'h1;
            cnt[e] = 8'h00;
        end
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        // Internal reset ends two edges after release
        repeat (3) @(posedge clk_sys);
        for (int e = 0; e < 16; e++) begin
            wb(1'b1, TSF_ADDR_EPSEL, e);
            sl = 4'(e);
            wb(1'b0, TSF_ADDR_FLAGS, 0);
            chk({24'h0, TSF_FLAGS_RST}, rd);
            wb(1'b0, TSF_ADDR_COUNT, 0);
            chk(rb(TSF_ADDR_COUNT), rd);
            wb(1'b0, TSF_ADDR_CTRL, 0);
            chk(rb(TSF_ADDR_CTRL), rd);
        end
    endtask : rst_chk
    // Two resets with per-copy checks around random traffic
    initial begin
        rst_chk();
        for (int i = 0; i < 700; i++) begin
            // Second reset in mid-run
            if (i == 350) rst_chk();
            r = xs();
            case (r[2:0])
                3'h0: begin
                    wb(1'b1, TSF_ADDR_EPSEL, r[11:8]);
                    if (r[28]) sl = r[11:8];
                end
                3'h1, 3'h2: begin
                    wb(1'b1, TSF_ADDR_COUNT, r[23:16]);
                    if (r[28]) begin
                        cnt[sl] = r[23:16];
                        que(sl);
                    end
                end
                3'h3: begin
                    ra = r[15:8] & 8'h86;
                    wb(1'b1, TSF_ADDR_CTRL, ra);
                    if (r[28]) at[sl] = r[10];
                    if (r[28] && r[15]) {pres[sl], ur[sl], ov[sl]} = 4'h0;
                    else if (r[28] && r[9] && !r[10]) adv(sl);
                end
                3'h4: begin
                    wb(1'b1, TSF_ADDR_FLAGS, r[23:16]);
                    if (r[28]) {ur[sl], ov[sl]} = r[17:16];
                end
                3'h5, 3'h6: begin
                    ev(r[0]);
                    if (!r[0]) ur[r[11:8]] = 1'b1;
                    else if (at[r[11:8]]) adv(r[11:8]);
                end
                default: begin
                    // Readback of any register, or an unmapped one
                    ra = r[14] ? 8'h10 : {4'h0, r[13:12], 2'h0};
                    wb(1'b0, ra, r);
                    chk(rb(ra), rd);
                end
            endcase
            wb(1'b0, TSF_ADDR_FLAGS, r);
            chk(fl(sl), rd);
        end
        test_done();
    end
endmodule : tb_top
